/* rtl/uep_ctrl.v */
// endpoint command/status control with apb registers and nak interrupt
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "uep_consts.vh"
module uep_ctrl #(
   parameter NEP = 8,
   parameter EPW = 3
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire tok_valid,
   input wire tok_dir,
   input wire [EPW-1:0] tok_ep,
   output reg [1:0] hs_code,
   output reg hs_valid,
   output reg hs_toggle,
   output reg [10:0] hs_mps,
   input wire tx_in_valid,
   input wire [7:0] tx_in_data,
   input wire tx_in_last,
   output reg tx_valid,
   output reg [7:0] tx_data,
   output reg tx_last,
   output reg irq
);
   wire setup;
   wire acc;
   wire [NEP-1:0] ep_nak;
   wire [NEP-1:0] ep_tog;
   wire [NEP*7-1:0] ep_cmd;
   wire [NEP*2-1:0] ep_xt;
   wire [NEP*11-1:0] ep_mps;
   wire [NEP-1:0] ep_wr;
   wire [NEP-1:0] ep_hit;
   wire tok_nak;
   wire nak_ev_out;
   wire nak_ev_in;
   wire ack_ev;
   wire stat_rd;
   wire p_valid;
   wire [7:0] p_data;
   wire p_last;
   wire [2:0] ev;
   reg [1:0] devcmd;
   reg [2:0] stat;
   reg [2:0] mask;
   reg [31:0] next_prdata;
   reg addr_ok;
   assign setup = psel & ~penable;
   assign acc = psel & penable & pready;
   genvar g;
   generate
      for (g = 0; g < NEP; g = g + 1) begin : ep
         assign ep_wr[g] = acc && pwrite &&
            paddr == (`UEP_OFS_EP0 + g * 4);
         assign ep_hit[g] = tok_valid && tok_ep == g;
         uep_ep_slot u_slot (
            .pclk(pclk),
            .presetn(presetn),
            .wr(ep_wr[g]),
            .wdata(pwdata[6:0]),
            .tok_hit(ep_hit[g]),
            .tok_ok(1'b1),
            .cmd(ep_cmd[g*7 +: 7]),
            .toggle(ep_tog[g]),
            .nak(ep_nak[g]),
            .xtype(ep_xt[g*2 +: 2]),
            .mps(ep_mps[g*11 +: 11])
         );
      end
   endgenerate
   assign tok_nak = ep_nak[tok_ep];
   assign nak_ev_out = tok_valid && tok_nak && tok_dir == `UEP_TOK_OUT &&
      devcmd[`UEP_DEV_BIT_NAKOUT];
   assign nak_ev_in = tok_valid && tok_nak && tok_dir == `UEP_TOK_IN &&
      devcmd[`UEP_DEV_BIT_NAKIN];
   assign ack_ev = tok_valid && !tok_nak;
   assign ev = {ack_ev, nak_ev_in, nak_ev_out};
   assign stat_rd = acc && !pwrite && paddr == `UEP_OFS_STAT;
   always @* begin
      next_prdata = 32'h00000000;
      addr_ok = 1'b1;
      case (paddr)
         `UEP_OFS_DEVCMD: next_prdata[1:0] = devcmd;
         `UEP_OFS_EPTOG: next_prdata[NEP-1:0] = ep_tog;
         `UEP_OFS_STAT: next_prdata[2:0] = stat;
         `UEP_OFS_MASK: next_prdata[2:0] = mask;
         default: begin
            if (paddr >= `UEP_OFS_EP0 && paddr < `UEP_OFS_EP0 + NEP * 4 &&
                paddr[1:0] == 2'b00) begin
               next_prdata[6:0] = ep_cmd[paddr[EPW+1:2]*7 +: 7];
            end else begin
               addr_ok = 1'b0;
            end
         end
      endcase
   end
   // no wait state: pready rises in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~addr_ok;
         if (setup && !pwrite) begin
            prdata <= next_prdata;
         end
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         devcmd <= 2'b00;
         mask <= 3'b000;
         stat <= 3'b000;
         irq <= 1'b0;
      end else begin
         if (acc && pwrite && paddr == `UEP_OFS_DEVCMD) begin
            devcmd <= pwdata[1:0];
         end
         if (acc && pwrite && paddr == `UEP_OFS_MASK) begin
            mask <= pwdata[2:0];
         end
         // a read clears only the bits it reported; an event that lands
         // between the setup capture and the access edge is not lost
         stat <= (stat & ~(stat_rd ? prdata[2:0] : 3'b000)) | ev;
         irq <= |(((stat & ~(stat_rd ? prdata[2:0] : 3'b000)) | ev) & mask);
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_valid <= 1'b0;
         hs_code <= `UEP_HS_NONE;
         hs_toggle <= 1'b0;
         hs_mps <= 11'h000;
      end else begin
         hs_valid <= tok_valid;
         hs_code <= !tok_valid ? `UEP_HS_NONE :
            (tok_nak ? `UEP_HS_NAK : `UEP_HS_ACK);
         hs_toggle <= ep_tog[tok_ep];
         hs_mps <= ep_mps[tok_ep*11 +: 11];
      end
   end
   uep_tx_path #(
      .DW(8)
   ) u_tx (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(tx_in_valid),
      .in_data(tx_in_data),
      .in_last(tx_in_last),
      .out_valid(p_valid),
      .out_data(p_data),
      .out_last(p_last)
   );
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
         tx_last <= 1'b0;
      end else begin
         tx_valid <= p_valid;
         tx_data <= p_data;
         tx_last <= p_last;
      end
   end
endmodule

/* rtl/uep_consts.vh */
// constants for the endpoint command/status block
`ifndef UEP_CONSTS_VH
`define UEP_CONSTS_VH
`define UEP_OFS_DEVCMD 12'h000
`define UEP_OFS_EPTOG 12'h004
`define UEP_OFS_STAT 12'h008
`define UEP_OFS_MASK 12'h00c
`define UEP_OFS_EP0 12'h040
`define UEP_EP_BIT_ACTIVE 0
`define UEP_EP_BIT_TR 1
`define UEP_EP_BIT_RFTV 2
`define UEP_EP_BIT_TYPE 3
`define UEP_EP_BIT_OUTDIR 4
`define UEP_EP_XTYPE_LO 5
`define UEP_EP_XTYPE_HI 6
`define UEP_DEV_BIT_NAKOUT 0
`define UEP_DEV_BIT_NAKIN 1
`define UEP_XT_CTRL 2'h0
`define UEP_XT_BULK 2'h1
`define UEP_XT_INT 2'h2
`define UEP_XT_ISO 2'h3
`define UEP_MPS_CTRL 11'h040
`define UEP_MPS_BULK 11'h200
`define UEP_MPS_INT 11'h400
`define UEP_MPS_ISO 11'h400
`define UEP_HS_NONE 2'h0
`define UEP_HS_ACK 2'h1
`define UEP_HS_NAK 2'h2
`define UEP_TOK_OUT 1'b0
`define UEP_TOK_IN 1'b1
`endif

/* rtl/uep_ep_slot.v */
// one endpoint entry: command bits, class decode and data toggle
`timescale 1ns/100ps
`include "uep_consts.vh"
module uep_ep_slot (
   input wire pclk,
   input wire presetn,
   input wire wr,
   input wire [6:0] wdata,
   input wire tok_hit,
   input wire tok_ok,
   output reg [6:0] cmd,
   output reg toggle,
   output wire nak,
   output wire [1:0] xtype,
   output reg [10:0] mps
);
   wire periodic;
   assign periodic = cmd[`UEP_EP_BIT_TYPE];
   assign nak = ~cmd[`UEP_EP_BIT_ACTIVE];
   // periodic class wins over the stored generic type
   assign xtype = periodic ? (cmd[`UEP_EP_BIT_RFTV] ? `UEP_XT_INT :
      `UEP_XT_ISO) : cmd[`UEP_EP_XTYPE_HI:`UEP_EP_XTYPE_LO];
   always @* begin
      case (xtype)
         `UEP_XT_CTRL: mps = `UEP_MPS_CTRL;
         `UEP_XT_BULK: mps = `UEP_MPS_BULK;
         `UEP_XT_INT: mps = `UEP_MPS_INT;
         default: mps = `UEP_MPS_ISO;
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd <= 7'h00;
         toggle <= 1'b0;
      end else begin
         if (wr) begin
            // the reset request is a one-shot; it is not kept in the entry
            cmd <= wdata & ~(7'h01 << `UEP_EP_BIT_TR);
         end
         if (wr && wdata[`UEP_EP_BIT_TR]) begin
            toggle <= wdata[`UEP_EP_BIT_RFTV];
         end else if (tok_hit && tok_ok && !nak) begin
            // iso endpoints carry no handshake toggle
            if (xtype != `UEP_XT_ISO) begin
               toggle <= ~toggle;
            end
         end
      end
   end
endmodule

/* rtl/uep_tx_path.v */
// in-direction byte path: payload passes through with one register stage
`timescale 1ns/100ps
module uep_tx_path #(
   parameter DW = 8
) (
   input wire pclk,
   input wire presetn,
   input wire in_valid,
   input wire [DW-1:0] in_data,
   input wire in_last,
   output reg out_valid,
   output reg [DW-1:0] out_data,
   output reg out_last
);
   // no dependence on any earlier out transfer length is kept here
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_data <= {DW{1'b0}};
         out_last <= 1'b0;
      end else begin
         out_valid <= in_valid;
         out_data <= in_data;
         out_last <= in_valid & in_last;
      end
   end
endmodule

/* tb/uep_checker.sv */
// port assertions for the endpoint control block
`timescale 1ns/100ps
module uep_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire tok_valid,
   input wire hs_valid,
   input wire tx_in_valid,
   input wire [7:0] tx_in_data,
   input wire tx_valid,
   input wire [7:0] tx_data
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_HS_AFTER_TOK: assert property (tok_valid |=> hs_valid)
      else $error("handshake missing");
   AST_HS_CAUSE: assert property (hs_valid |-> $past(tok_valid))
      else $error("handshake without token");
   AST_TX_DATA: assert property (tx_in_valid |-> ##2
      tx_valid && tx_data == $past(tx_in_data, 2))
      else $error("payload byte altered");
   AST_TX_IDLE: assert property (!tx_in_valid |-> ##2 !tx_valid)
      else $error("payload byte invented");
   AST_TX_CAUSE: assert property (tx_valid |-> $past(tx_in_valid, 2))
      else $error("payload out of step");
   AST_RDY_ACCESS: assert property (psel && !penable |=> pready)
      else $error("register access stalled");
   AST_RDY_PULSE: assert property (pready |=> !pready)
      else $error("ready held too long");
   AST_RDY_CAUSE: assert property (pready |-> psel && penable)
      else $error("ready outside access");
endmodule
bind uep_ctrl uep_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pready(pready), .tok_valid(tok_valid),
   .hs_valid(hs_valid), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
   .tx_valid(tx_valid), .tx_data(tx_data));

/* tb/uep_host.sv */
// host model: sends tokens and collects the handshake
`timescale 1ns/100ps
module uep_host (
   input wire pclk,
   output reg tok_valid,
   output reg tok_dir,
   output reg [2:0] tok_ep,
   input wire hs_valid,
   input wire [1:0] hs_code,
   input wire hs_toggle,
   input wire [10:0] hs_mps
);
   reg [14:0] got;
   initial begin
      tok_valid = 1'h0;
      tok_dir = 1'h0;
      tok_ep = 3'h0;
   end
   // released lines flip so a stale value cannot pass as a new token
   task token(input d, input [2:0] e);
      begin
         tok_valid <= 1'h1;
         tok_dir <= d;
         tok_ep <= e;
         @(posedge pclk);
         tok_valid <= 1'h0;
         tok_dir <= ~d;
         tok_ep <= ~e;
         @(posedge pclk);
         got = {hs_valid, hs_code, hs_toggle, hs_mps};
      end
   endtask
endmodule

/* tb/tb_usb_hs_device_endpoint_control.sv */
// self-checking bench for the endpoint control block
`timescale 1ns/100ps
module tb_usb_hs_device_endpoint_control;
   reg pclk, presetn, psel, penable, pwrite, tx_in_valid, tx_in_last, er;
   reg [11:0] paddr;
   reg [31:0] pwdata, rd;
   reg [7:0] tx_in_data;
   wire pready, pslverr, tok_valid, tok_dir, hs_valid, hs_toggle, irq;
   wire tx_valid, tx_last;
   wire [31:0] prdata;
   wire [2:0] tok_ep;
   wire [1:0] hs_code;
   wire [10:0] hs_mps;
   wire [7:0] tx_data;
   integer n_fail, checked, i;
   // row: endpoint word, dir, handshake (3 = not compared), toggle, mps
   reg [21:0] row [0:7];
   uep_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tok_valid(tok_valid), .tok_dir(tok_dir), .tok_ep(tok_ep),
      .hs_code(hs_code), .hs_valid(hs_valid), .hs_toggle(hs_toggle),
      .hs_mps(hs_mps), .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
      .tx_in_last(tx_in_last), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .irq(irq));
   uep_host host (.pclk(pclk), .tok_valid(tok_valid), .tok_dir(tok_dir),
      .tok_ep(tok_ep), .hs_valid(hs_valid), .hs_code(hs_code),
      .hs_toggle(hs_toggle), .hs_mps(hs_mps));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'h1;
         @(posedge pclk);
         while (pready !== 1'h1) @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge pclk);
      end
   endtask
   task finish_test;
      begin
         $display("checked %0d n_fail %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      pclk = 1'h0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      #100000;
      n_fail = n_fail + 1;
      finish_test;
   end
   initial begin
      n_fail = 0;
      checked = 0;
      presetn = 1'h0;
      {psel, penable, pwrite, paddr, pwdata} = 0;
      {tx_in_valid, tx_in_last, tx_in_data} = 0;
      row = '{22'h016040, 22'h039840, 22'h00d040, 22'h109a00,
         22'h07dc00, 22'h05f400, 22'h04f400, 22'h069400};
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      chk({irq, tx_valid, hs_valid}, 32'h0);
      @(posedge pclk);
      apb(1'h1, 12'h000, 32'h3);
      apb(1'h1, 12'h00c, 32'h0);
      for (i = 0; i < 8; i = i + 1) begin
         apb(1'h1, 12'h040, {25'h0, row[i][21:15]});
         host.token(row[i][14], 3'h0);
         if (row[i][13:12] != 2'h3)
            chk(host.got[13:12], row[i][13:12]);
         chk({host.got[14], host.got[11:0]}, {1'h1, row[i][11:0]});
      end
      $display("endpoint table done");
      apb(1'h0, 12'h008, 32'h0);
      apb(1'h1, 12'h00c, 32'h3);
      apb(1'h1, 12'h044, 32'h0);
      host.token(1'h0, 3'h1);
      @(posedge pclk);
      chk(irq, 32'h1);
      apb(1'h0, 12'h008, 32'h0);
      chk(rd, 32'h1);
      @(posedge pclk);
      chk(irq, 32'h0);
      apb(1'h1, 12'h000, 32'h1);
      host.token(1'h1, 3'h1);
      @(posedge pclk);
      chk(irq, 32'h0);
      apb(1'h1, 12'h040, 32'h3);
      apb(1'h0, 12'h004, 32'h0);
      chk(rd[0], 32'h0);
      apb(1'h1, 12'h040, 32'h7);
      apb(1'h0, 12'h004, 32'h0);
      chk(rd[0], 32'h1);
      apb(1'h0, 12'h020, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      $display("interrupt and register tests done");
      for (i = 0; i < 7; i = i + 1) begin
         tx_in_valid <= i < 5;
         tx_in_data <= 8'ha0 + i[7:0];
         tx_in_last <= i == 4;
         @(posedge pclk);
         if (i > 1)
            chk({tx_valid, tx_last, tx_data}, {1'h1, i == 6, i[7:0] + 8'h9e});
      end
      $display("payload test done");
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      chk({irq, tx_valid, hs_valid}, 32'h0);
      @(posedge pclk);
      apb(1'h0, 12'h004, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, 12'h040, 32'h0);
      chk(rd, 32'h0);
      $display("mid-run reset test done");
      finish_test;
   end
endmodule
